/* File: common/pll_ctl_pkg.sv */
// Purpose: shared constants and types for the pll control latches
// Assumes: 24-bit serial control words, two select bits in the low end
// Notes: bit positions are within the shifted word
package pll_ctl_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_LO = 0;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // feedback divide word fields
  localparam int GAIN_POS = 21;
  localparam int RATIO_LO = 8;
  localparam int RATIO_W = 13;
  // function and initialization word fields
  localparam int CNT_RST_POS = 2;
  localparam int PD1_POS = 3;
  localparam int MUX_LO = 4;
  localparam int MUX_W = 3;
  localparam int PD_POL_POS = 7;
  localparam int CP_TRI_POS = 8;
  localparam int FL_EN_POS = 9;
  localparam int FL_MODE_POS = 10;
  localparam int TC_LO = 11;
  localparam int TC_W = 4;
  localparam int CUR1_LO = 15;
  localparam int CUR2_LO = 18;
  localparam int CUR_W = 3;
  localparam int PD2_POS = 21;
  localparam int MUX_SRC_N = 8;
  // fastlock timer: timeout is (select + 1) * step phase detector cycles
  localparam int TIMER_W = 7;
  localparam logic [TIMER_W-1:0] TIMEOUT_STEP = 7'h04;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h00_0000;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 13'h0001;

  typedef struct packed {
    logic powerdown_sync_select;
    logic [CUR_W-1:0] current_two;
    logic [CUR_W-1:0] current_one;
    logic [TC_W-1:0] fastlock_timeout_select;
    logic fastlock_mode_bit;
    logic fastlock_enable_bit;
    logic charge_pump_tristate_bit;
    logic pd_polarity;
    logic [MUX_W-1:0] output_mux_select;
    logic powerdown_enable_bit;
    logic counter_reset_bit;
  } func_t;

  localparam func_t FUNC_RESET = '0;
endpackage

/* File: verilog/pll_control_latches.sv */
// Purpose: serial control-word latches and control logic of a clock pll
// Assumes: host holds the serial clock still while load_strobe is high
// Notes: serial shifting on serial_clk, everything else on clk
//
// Functional notes
// - words shift in msb first, one bit per rising serial clock edge
// - load strobe rising edge copies shifted word into selected latch
// - bits 1 and 0 of the word select the destination latch
// - feedback divide ratio 1..8191 taken straight from 13-bit field
// - select value two loads the function latch
// - counter reset bit holds counters reset while one
// - power-down bits act only while chip enable permits operation
// - chip enable low powers down at once regardless of bits
// - enable bit with sync select zero powers down immediately
// - enable and sync select both one wait for next pump event
// - power-down loads counters, three-states pump, resets lock detect
// - shift register keeps working while powered down
// - three mux select bits choose the mux output source
// - fastlock enabled only when enable bit 9 is one
// - mode bit 10 picks mode 1 or 2; fastlock uses current two
// - mode 1: gain write one enters, gain write zero exits
// - mode 2: timeout clears gain bit, back to current one
// - timeout select bits 14..11; timer runs only in mode 2
// - low current bits give static current, high give fastlock
// - tristate bit one floats pump output, zero enables it
// - select three loads function fields and fires reset pulse
// - reset pulse loads counters, three-states pump, oscillator runs
// - reset pulse also triggers a selected synchronous power-down
// - first divide load after init fires pulse again, later ones not
// - latched words survive chip enable cycling
`timescale 1ns/1ps
`default_nettype none
module pll_control_latches (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic pd_event,
  input wire logic [pll_ctl_pkg::MUX_SRC_N-1:0] mux_sources,
  output logic [pll_ctl_pkg::WORD_W-1:0] ref_word,
  output logic [pll_ctl_pkg::RATIO_W-1:0] divide_ratio,
  output logic charge_pump_gain_bit,
  output pll_ctl_pkg::func_t func,
  output logic counter_reset_pulse,
  output logic powered_down,
  output logic counters_load,
  output logic cp_drive_en,
  output logic lock_detect_reset,
  output logic fastlock_active,
  output logic [pll_ctl_pkg::CUR_W-1:0] cp_current,
  output logic mux_output_pin
);
  import pll_ctl_pkg::*;

  logic rst_meta;
  logic rst_n;
  logic [WORD_W-1:0] shift_reg;
  logic le_meta;
  logic le_sync;
  logic le_prev;
  logic ce_meta;
  logic ce_sync;
  logic le_rise;
  logic [SEL_W-1:0] sel;
  logic load_ref;
  logic load_fb;
  logic load_func;
  logic load_init;
  logic init_armed;
  logic sync_down;
  logic sync_mode;
  logic timer_run;
  logic timeout_hit;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] timer_limit;

  // unpack a function or initialization word
  function automatic func_t decode_func(input logic [WORD_W-1:0] w);
    func_t f;
    f.powerdown_sync_select = w[PD2_POS];
    f.current_two = w[CUR2_LO +: CUR_W];
    f.current_one = w[CUR1_LO +: CUR_W];
    f.fastlock_timeout_select = w[TC_LO +: TC_W];
    f.fastlock_mode_bit = w[FL_MODE_POS];
    f.fastlock_enable_bit = w[FL_EN_POS];
    f.charge_pump_tristate_bit = w[CP_TRI_POS];
    f.pd_polarity = w[PD_POL_POS];
    f.output_mux_select = w[MUX_LO +: MUX_W];
    f.powerdown_enable_bit = w[PD1_POS];
    f.counter_reset_bit = w[CNT_RST_POS];
    return f;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // input shift register on the serial clock, never gated by power-down
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= WORD_RESET;
    end else begin
      shift_reg <= {shift_reg[WORD_W-2:0], serial_data};
    end
  end

  // pin synchronisers for load strobe and chip enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      le_meta <= 1'b0;
      le_sync <= 1'b0;
      le_prev <= 1'b0;
      ce_meta <= 1'b0;
      ce_sync <= 1'b0;
    end else begin
      le_meta <= load_strobe;
      le_sync <= le_meta;
      le_prev <= le_sync;
      ce_meta <= chip_enable;
      ce_sync <= ce_meta;
    end
  end

  // shift_reg is static while the strobe is high, so the qualified capture is safe
  assign le_rise = le_sync & ~le_prev;
  assign sel = shift_reg[SEL_LO +: SEL_W];
  assign load_ref = le_rise & (sel == SEL_REF);
  assign load_fb = le_rise & (sel == SEL_FB);
  assign load_func = le_rise & (sel == SEL_FUNC);
  assign load_init = le_rise & (sel == SEL_INIT);

  // word latches, untouched by chip enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_word <= WORD_RESET;
      divide_ratio <= RATIO_RESET;
      func <= FUNC_RESET;
    end else begin
      if (load_ref) begin
        ref_word <= shift_reg;
      end
      if (load_fb) begin
        divide_ratio <= shift_reg[RATIO_LO +: RATIO_W];
      end
      if (load_func || load_init) begin
        func <= decode_func(shift_reg);
      end
    end
  end

  // gain bit: host write wins over the timeout clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_gain_bit <= 1'b0;
    end else if (load_fb) begin
      charge_pump_gain_bit <= shift_reg[GAIN_POS];
    end else if (timeout_hit) begin
      charge_pump_gain_bit <= 1'b0;
    end
  end

  // internal reset pulse from init load and the first divide load after it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_armed <= 1'b0;
      counter_reset_pulse <= 1'b0;
    end else begin
      counter_reset_pulse <= load_init | (load_fb & init_armed);
      if (load_init) begin
        init_armed <= 1'b1;
      end else if (load_fb) begin
        init_armed <= 1'b0;
      end
    end
  end

  // synchronous power-down waits for a pump event or the reset pulse
  assign sync_mode = func.powerdown_enable_bit & func.powerdown_sync_select;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_down <= 1'b0;
    end else if (sync_mode && (pd_event || counter_reset_pulse)) begin
      sync_down <= 1'b1;
    end else if (!sync_mode) begin
      sync_down <= 1'b0;
    end
  end

  // power-down and counter load state
  assign powered_down = ~ce_sync | (ce_sync & ((func.powerdown_enable_bit & ~func.powerdown_sync_select) | sync_down));
  assign counters_load = powered_down | func.counter_reset_bit | counter_reset_pulse;
  assign cp_drive_en = ~(counters_load | func.charge_pump_tristate_bit);
  assign lock_detect_reset = powered_down;

  // fastlock current selection
  assign fastlock_active = func.fastlock_enable_bit & charge_pump_gain_bit;
  assign cp_current = fastlock_active ? func.current_two : func.current_one;

  // mode 2 timeout counter, counted in phase detector cycles
  assign timer_limit = TIMER_W'(({3'h0, func.fastlock_timeout_select} + 7'h01) * TIMEOUT_STEP);
  assign timer_run = fastlock_active & func.fastlock_mode_bit & ~counters_load;
  assign timeout_hit = timer_run & pd_event & (timer == timer_limit - 7'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= '0;
    end else if (!timer_run || load_fb || timeout_hit) begin
      timer <= '0;
    end else if (pd_event) begin
      timer <= timer + 7'h01;
    end
  end

  // registered output multiplexer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_output_pin <= 1'b0;
    end else begin
      mux_output_pin <= mux_sources[func.output_mux_select];
    end
  end

  // checks
  chk_ce_low_down: assert property (@(posedge clk) disable iff (!rst_n) !ce_sync |-> powered_down)
    else $error("chip enable low without power-down");
  chk_pd_effects: assert property (@(posedge clk) disable iff (!rst_n)
    powered_down |-> (counters_load && !cp_drive_en && lock_detect_reset))
    else $error("power-down effects missing");
  chk_async_pd: assert property (@(posedge clk) disable iff (!rst_n)
    ce_sync && func.powerdown_enable_bit && !func.powerdown_sync_select |-> powered_down)
    else $error("asynchronous power-down not taken");
  chk_sync_pd_wait: assert property (@(posedge clk) disable iff (!rst_n)
    ce_sync && sync_mode && !sync_down && !pd_event && !counter_reset_pulse |=> !sync_down)
    else $error("synchronous power-down entered without event");
  chk_sync_pd_event: assert property (@(posedge clk) disable iff (!rst_n)
    sync_mode && pd_event ##1 sync_mode |-> powered_down)
    else $error("synchronous power-down missed pump event");
  chk_init_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    load_init |=> counter_reset_pulse && counters_load && !cp_drive_en)
    else $error("init load gave no reset pulse");
  chk_fb_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
    load_fb && !init_armed |=> !counter_reset_pulse)
    else $error("repeated divide load fired reset pulse");
  chk_func_load: assert property (@(posedge clk) disable iff (!rst_n)
    load_func |=> func.output_mux_select == $past(shift_reg[MUX_LO +: MUX_W])
      && func.counter_reset_bit == $past(shift_reg[CNT_RST_POS]))
    else $error("function word not latched");
  chk_fl_current: assert property (@(posedge clk) disable iff (!rst_n)
    fastlock_active |-> cp_current == func.current_two)
    else $error("fastlock not on current two");
  chk_mode1_hold: assert property (@(posedge clk) disable iff (!rst_n)
    charge_pump_gain_bit && !func.fastlock_mode_bit && !load_fb |=> charge_pump_gain_bit)
    else $error("mode 1 fastlock left without write");
  chk_timeout_clear: assert property (@(posedge clk) disable iff (!rst_n)
    timeout_hit && !load_fb |=> !charge_pump_gain_bit && cp_current == func.current_one)
    else $error("timeout did not end fastlock");
  chk_timer_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !func.fastlock_mode_bit |=> timer == '0)
    else $error("timer ran outside mode 2");
  chk_tristate: assert property (@(posedge clk) disable iff (!rst_n)
    func.charge_pump_tristate_bit |-> !cp_drive_en)
    else $error("pump driven while three-stated");
  // counter reset bit alone must hold the counters at load
  chk_cnt_reset_hold: assert property (@(posedge clk) disable iff (!rst_n)
    func.counter_reset_bit |-> counters_load)
    else $error("counter reset bit did not hold counters");
  // the internal pulse loads the counters and floats the pump in its cycle
  chk_pulse_effects: assert property (@(posedge clk) disable iff (!rst_n)
    counter_reset_pulse |-> (counters_load && !cp_drive_en))
    else $error("reset pulse effects missing");
  // the pulse is a single cycle wide
  chk_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    counter_reset_pulse |=> !counter_reset_pulse)
    else $error("reset pulse longer than one cycle");
  // the mux pin follows the selected source one cycle later
  chk_mux_follow: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mux_output_pin == $past(mux_sources[func.output_mux_select]))
    else $error("mux output does not follow selected source");
  // without the enable bit the pump stays on the static current
  chk_fl_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    !func.fastlock_enable_bit |-> (!fastlock_active && cp_current == func.current_one))
    else $error("fastlock active while disabled");
  // divide word load takes ratio and gain from the shifted word
  chk_fb_load: assert property (@(posedge clk) disable iff (!rst_n)
    load_fb |=> divide_ratio == $past(shift_reg[RATIO_LO +: RATIO_W])
      && charge_pump_gain_bit == $past(shift_reg[GAIN_POS]))
    else $error("divide word not latched");
  // reference word load copies the whole shifted word
  chk_ref_load: assert property (@(posedge clk) disable iff (!rst_n)
    load_ref |=> ref_word == $past(shift_reg))
    else $error("reference word not latched");
  // function fields change only on a function or init load
  chk_func_retain: assert property (@(posedge clk) disable iff (!rst_n)
    !load_func && !load_init |=> func == $past(func))
    else $error("function fields changed without a load");
  // with chip enable high and no enable bit the device runs
  chk_pd_released: assert property (@(posedge clk) disable iff (!rst_n)
    ce_sync && !func.powerdown_enable_bit ##1 ce_sync && !func.powerdown_enable_bit |-> !powered_down)
    else $error("powered down without a cause");
endmodule
`default_nettype wire

/* File: dv/pll_host_model.sv */
// Purpose: host model that shifts control words into the pll latches
// Assumes: serial clock period of 80 ns, unrelated in phase to clk
// Notes: serial clock stands low outside frames; data shows ~last bit
`timescale 1ns/1ps
`default_nettype none
module pll_host_model (
  input wire logic clk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  import pll_ctl_pkg::*;
  // idle levels at time zero
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  // one frame: 24 bits msb first, then strobe high 4 clk, low 6 clk
  task automatic send(input logic [WORD_W-1:0] w);
    #13;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serial_data = w[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    serial_data = ~w[0]; // released line must not keep the last bit
    @(posedge clk);
    load_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    load_strobe <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: self-checking bench for the pll control latches
// Assumes: host model drives the serial port, bench drives the rest
// Notes: expected values come from the bench's own word builders
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pll_ctl_pkg::*;
  logic clk, reset_n, chip_enable, pd_event, serial_clk, serial_data, load_strobe;
  logic [MUX_SRC_N-1:0] mux_sources;
  logic [WORD_W-1:0] ref_word, w;
  logic [RATIO_W-1:0] divide_ratio, r;
  logic charge_pump_gain_bit, counter_reset_pulse, powered_down, counters_load, cp_drive_en;
  logic lock_detect_reset, fastlock_active, mux_output_pin;
  logic [CUR_W-1:0] cp_current;
  func_t func, f;
  int num_errors = 0, check_count = 0, pulses = 0, p0;
  int unsigned seed_v;

  pll_control_latches u_pll_control_latches (.clk, .reset_n, .serial_clk, .serial_data, .load_strobe,
    .chip_enable, .pd_event, .mux_sources, .ref_word, .divide_ratio, .charge_pump_gain_bit, .func,
    .counter_reset_pulse, .powered_down, .counters_load, .cp_drive_en, .lock_detect_reset,
    .fastlock_active, .cp_current, .mux_output_pin);
  pll_host_model u_host (.clk, .serial_clk, .serial_data, .load_strobe);

  // 50 ns system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count internal reset pulses
  always @(posedge clk) begin
    if (counter_reset_pulse === 1'b1) pulses <= pulses + 1;
  end

  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic pev();
    @(posedge clk) pd_event <= 1'b1;
    @(posedge clk) pd_event <= 1'b0;
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // function or init word, reserved top bits random
  function automatic logic [WORD_W-1:0] fw(input func_t x, input logic [1:0] s);
    return {2'($urandom), x, s};
  endfunction
  // divide word with random ignored bits
  function automatic logic [WORD_W-1:0] dw(input logic g, input logic [RATIO_W-1:0] n);
    return {2'($urandom), g, n, 6'($urandom), SEL_FB};
  endfunction
  // random settings with power-down, reset, tristate and fastlock off
  function automatic func_t rf();
    func_t x;
    x = func_t'(20'($urandom));
    x.counter_reset_bit = 1'b0;
    x.powerdown_enable_bit = 1'b0;
    x.powerdown_sync_select = 1'b0;
    x.charge_pump_tristate_bit = 1'b0;
    x.fastlock_enable_bit = 1'b0;
    return x;
  endfunction

  // hang guard
  initial begin
    #500_000;
    num_errors++;
    final_report();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    chip_enable = 1'b1;
    pd_event = 1'b0;
    mux_sources = '0;
    seed_v = $urandom(32'h8488);
    wclk(8);
    reset_n <= 1'b1;
    wclk(4);
    f = rf();
    p0 = pulses;
    u_host.send(fw(f, SEL_INIT));
    chk(func, f);
    chk(24'(pulses - p0), 24'h00_0001);
    w = {22'($urandom), SEL_REF};
    u_host.send(w);
    chk(ref_word, w);
    r = 13'($urandom % 8191 + 1);
    u_host.send(dw(1'b1, r));
    chk(divide_ratio, r);
    chk(charge_pump_gain_bit, 1'b1);
    chk(24'(pulses - p0), 24'h00_0002);
    u_host.send(dw(1'b0, 13'h1fff));
    chk(divide_ratio, 13'h1fff);
    chk(24'(pulses - p0), 24'h00_0002);
    $display("test init sequence done");
    for (int s = 0; s < MUX_SRC_N; s++) begin
      f.output_mux_select = 3'(s);
      u_host.send(fw(f, SEL_FUNC));
      @(posedge clk) mux_sources <= 8'($urandom);
      wclk(3);
      chk(func, f);
      chk(mux_output_pin, mux_sources[s]);
    end
    $display("test mux select done");
    f.current_two = ~f.current_one;
    f.fastlock_timeout_select = 4'h1;
    f.fastlock_mode_bit = 1'b0;
    u_host.send(fw(f, SEL_FUNC));
    u_host.send(dw(1'b1, r));
    chk(fastlock_active, 1'b0);
    chk(cp_current, f.current_one);
    f.fastlock_enable_bit = 1'b1;
    u_host.send(fw(f, SEL_FUNC));
    chk(fastlock_active, 1'b1);
    chk(cp_current, f.current_two);
    repeat (10) pev();
    chk(charge_pump_gain_bit, 1'b1);
    u_host.send(dw(1'b0, r));
    chk(cp_current, f.current_one);
    f.fastlock_mode_bit = 1'b1;
    u_host.send(fw(f, SEL_FUNC));
    u_host.send(dw(1'b1, r));
    repeat (7) pev();
    chk(charge_pump_gain_bit, 1'b1);
    pev();
    wclk(2);
    chk(charge_pump_gain_bit, 1'b0);
    chk(cp_current, f.current_one);
    $display("test fastlock done");
    f.fastlock_enable_bit = 1'b0;
    f.charge_pump_tristate_bit = 1'b1;
    u_host.send(fw(f, SEL_FUNC));
    chk(cp_drive_en, 1'b0);
    f.charge_pump_tristate_bit = 1'b0;
    f.counter_reset_bit = 1'b1;
    u_host.send(fw(f, SEL_FUNC));
    chk(counters_load, 1'b1);
    f.counter_reset_bit = 1'b0;
    u_host.send(fw(f, SEL_FUNC));
    chk(counters_load, 1'b0);
    chk(cp_drive_en, 1'b1);
    $display("test tristate and counter reset done");
    chip_enable <= 1'b0;
    wclk(4);
    chk(powered_down, 1'b1);
    chk(counters_load, 1'b1);
    chk(lock_detect_reset, 1'b1);
    chk(cp_drive_en, 1'b0);
    r = 13'($urandom % 8191 + 1);
    u_host.send(dw(1'b0, r));
    chk(divide_ratio, r);
    chip_enable <= 1'b1;
    wclk(4);
    chk(powered_down, 1'b0);
    chk(divide_ratio, r);
    chk(func, f);
    f.powerdown_enable_bit = 1'b1;
    u_host.send(fw(f, SEL_FUNC));
    chk(powered_down, 1'b1);
    f.powerdown_sync_select = 1'b1;
    u_host.send(fw(f, SEL_FUNC));
    chk(powered_down, 1'b0);
    pev();
    wclk(2);
    chk(powered_down, 1'b1);
    f.powerdown_enable_bit = 1'b0;
    u_host.send(fw(f, SEL_FUNC));
    chk(powered_down, 1'b0);
    f.powerdown_enable_bit = 1'b1;
    u_host.send(fw(f, SEL_INIT));
    chk(powered_down, 1'b1);
    $display("test power-down done");
    final_report();
  end
endmodule
`default_nettype wire
